// [shared/ccr_pkg.sv]
// Package: register map and field layout of the colour result readout
package ccr_pkg;
  localparam int          CCR_RES_W       = 16;
  localparam int          CCR_BYTE_W      = 8;
  localparam int          CCR_NUM_CH      = 4;
  localparam logic [7:0]  CCR_STATUS_ADDR = 8'h13;
  localparam logic [7:0]  CCR_CLEAR_LO    = 8'h14;
  localparam logic [7:0]  CCR_CLEAR_HI    = 8'h15;
  localparam logic [7:0]  CCR_RED_LO      = 8'h16;
  localparam logic [7:0]  CCR_RED_HI      = 8'h17;
  localparam logic [7:0]  CCR_GREEN_LO    = 8'h18;
  localparam logic [7:0]  CCR_GREEN_HI    = 8'h19;
  localparam logic [7:0]  CCR_BLUE_LO     = 8'h1A;
  localparam logic [7:0]  CCR_BLUE_HI     = 8'h1B;
  localparam int          CCR_VALID_BIT   = 0;
  localparam logic [15:0] CCR_RES_RST     = 16'h0000;
  localparam logic [7:0]  CCR_BYTE_RST    = 8'h00;
  localparam logic [7:0]  CCR_UNMAPPED    = 8'h00;
endpackage

// [src/ccr_readout.sv]
// Module: colour channel result registers with high-byte shadow
`timescale 1ns/1ns

// Overview of operation
// - Four 16-bit results are kept, low byte at the even address, from 0x14 to 0x1B.
// - A read of any low byte copies that channel's upper byte into the shadow register.
// - A read of a high byte returns the shadow, not the live result.
// - Interrupt and serial lines are open drain: pull low or release only.
// - Status bit 0 at 0x13 sets once all four channels finish an integration.
module ccr_readout
  import ccr_pkg::*;
(
  input  wire logic                            clk_sys_i,
  input  wire logic                            sys_rst_i,
  // Integration engine side
  input  wire logic                            integ_done_i,
  input  wire logic [CCR_NUM_CH*CCR_RES_W-1:0] integ_result_i,
  input  wire logic                            irq_assert_i,
  // Register port from the serial bus engine
  input  wire logic                            reg_rd_i,
  input  wire logic [7:0]                      reg_addr_i,
  output logic      [7:0]                      reg_rdata_o,
  // Open-drain pin drives from the serial bus engine
  input  wire logic                            sda_pull_low_i,
  input  wire logic                            scl_pull_low_i,
  output logic                                 int_o,
  output logic                                 int_oe_n_o,
  output logic                                 sda_o,
  output logic                                 sda_oe_n_o,
  output logic                                 scl_o,
  output logic                                 scl_oe_n_o,
  output logic                                 results_valid_flag_o
);

  // ==========================================================
  // Storage
  logic [CCR_RES_W-1:0]  result_q [CCR_NUM_CH];
  logic [CCR_BYTE_W-1:0] shadow_q;
  logic                  valid_q;
  logic [7:0]            rdata_q;

  // ==========================================================
  // Helpers
  function automatic logic addr_in_results(input logic [7:0] a);
    return (a >= CCR_CLEAR_LO) && (a <= CCR_BLUE_HI);
  endfunction

  function automatic logic [7:0] addr_offset(input logic [7:0] a);
    return a - CCR_CLEAR_LO;
  endfunction

  function automatic logic [1:0] chan_of(input logic [7:0] a);
    logic [7:0] rel;
    rel = addr_offset(a);
    return rel[2:1];
  endfunction

  function automatic logic upper_of(input logic [7:0] a);
    logic [7:0] rel;
    rel = addr_offset(a);
    return rel[0];
  endfunction

  function automatic logic [CCR_BYTE_W-1:0] res_byte(input logic [CCR_RES_W-1:0] r,
                                                    input logic                 upper);
    return upper ? r[CCR_RES_W-1 -: CCR_BYTE_W] : r[CCR_BYTE_W-1:0];
  endfunction

  // ==========================================================
  // Address decode
  wire logic       in_range   = addr_in_results(reg_addr_i);
  wire logic [1:0] ch_sel     = chan_of(reg_addr_i);
  wire logic       hi_sel     = upper_of(reg_addr_i);
  wire logic       lo_read    = reg_rd_i && in_range && !hi_sel;
  wire logic       hi_read    = reg_rd_i && in_range && hi_sel;
  wire logic       stat_read  = reg_rd_i && (reg_addr_i == CCR_STATUS_ADDR);
  wire logic       unmap_read = reg_rd_i && !in_range && !stat_read;
  wire logic [7:0] lo_byte    = res_byte(result_q[ch_sel], 1'b0);
  wire logic [7:0] hi_byte    = res_byte(result_q[ch_sel], 1'b1);
  wire logic [7:0] status_v   = 8'(valid_q) << CCR_VALID_BIT;

  // ==========================================================
  // Live results
  always_ff @(posedge clk_sys_i) begin
    for (int i = 0; i < CCR_NUM_CH; i++) begin
      if (sys_rst_i) begin
        result_q[i] <= CCR_RES_RST;
      end else if (integ_done_i) begin
        result_q[i] <= integ_result_i[i*CCR_RES_W +: CCR_RES_W];
      end
    end
  end

  // ==========================================================
  // Shadow of the upper byte
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      shadow_q <= CCR_BYTE_RST;
    end else if (lo_read) begin
      shadow_q <= hi_byte;
    end
  end

  // ==========================================================
  // Valid flag
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      valid_q <= 1'b0;
    end else if (integ_done_i) begin
      valid_q <= 1'b1;
    end
  end

  // ==========================================================
  // Read data
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rdata_q <= CCR_UNMAPPED;
    end else if (lo_read) begin
      rdata_q <= lo_byte;
    end else if (hi_read) begin
      rdata_q <= shadow_q;
    end else if (stat_read) begin
      rdata_q <= status_v;
    end else if (unmap_read) begin
      rdata_q <= CCR_UNMAPPED;
    end
  end

  assign reg_rdata_o          = rdata_q;
  assign results_valid_flag_o = valid_q;

  // ==========================================================
  // Open-drain pins
  // Data always 0; only the enables move
  assign int_o      = 1'b0;
  assign int_oe_n_o = !irq_assert_i;
  assign sda_o      = 1'b0;
  assign sda_oe_n_o = !sda_pull_low_i;
  assign scl_o      = 1'b0;
  assign scl_oe_n_o = !scl_pull_low_i;

  // ==========================================================
  // Checks
  chk_shadow_capture: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    lo_read |=> shadow_q == $past(hi_byte))
    else $error("shadow not captured on low read");

  chk_high_from_shadow: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    hi_read |=> reg_rdata_o == $past(shadow_q))
    else $error("high byte not from shadow");

  chk_high_not_live: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    hi_read && (shadow_q != hi_byte) |=> reg_rdata_o != $past(hi_byte))
    else $error("high byte read returned the live result");

  chk_shadow_holds: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !lo_read |=> $stable(shadow_q))
    else $error("shadow changed without low read");

  chk_result_holds: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !integ_done_i |=> $stable(result_q[0]) && $stable(result_q[1]) &&
                      $stable(result_q[2]) && $stable(result_q[3]))
    else $error("result changed outside integration end");

  chk_result_load: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    integ_done_i |=>
      (result_q[0] == $past(integ_result_i[0*CCR_RES_W +: CCR_RES_W])) &&
      (result_q[1] == $past(integ_result_i[1*CCR_RES_W +: CCR_RES_W])) &&
      (result_q[2] == $past(integ_result_i[2*CCR_RES_W +: CCR_RES_W])) &&
      (result_q[3] == $past(integ_result_i[3*CCR_RES_W +: CCR_RES_W])))
    else $error("results not loaded at integration end");

  // Same-cycle done and low read: old result wins
  chk_done_read_old: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    lo_read && integ_done_i |=> reg_rdata_o == $past(lo_byte) && shadow_q == $past(hi_byte))
    else $error("low read during integration end took the new result");

  chk_low_byte_read: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    lo_read |=> reg_rdata_o == $past(lo_byte))
    else $error("low byte read wrong");

  chk_unmapped_zero: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    unmap_read |=> reg_rdata_o == CCR_UNMAPPED)
    else $error("unmapped read not zero");

  chk_rdata_stands: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");

  chk_valid_sets: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    integ_done_i |=> results_valid_flag_o)
    else $error("valid flag not set");

  chk_valid_stays: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    results_valid_flag_o |=> results_valid_flag_o)
    else $error("valid flag dropped");

  chk_valid_only_done: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !integ_done_i && !results_valid_flag_o |=> !results_valid_flag_o)
    else $error("valid flag set without integration end");

  chk_status_read: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    stat_read |=> reg_rdata_o[CCR_VALID_BIT] == $past(valid_q))
    else $error("status valid bit wrong");

  chk_status_reserved: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    stat_read |=>
      (reg_rdata_o & ~(8'h01 << CCR_VALID_BIT)) == 8'h00)
    else $error("status reserved bits not zero");

  chk_open_drain: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !int_o && !sda_o && !scl_o && (int_oe_n_o == !irq_assert_i))
    else $error("pin driven high");

  chk_bus_release: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (sda_oe_n_o == !sda_pull_low_i) &&
    (scl_oe_n_o == !scl_pull_low_i))
    else $error("serial line enable does not follow its pull request");

endmodule

// [sim/ccr_host_model.sv]
// Host model issuing register byte reads
`timescale 1ns/1ns
module ccr_host_model (
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] rdata_i,
  output logic            rd_o,
  output logic [7:0]      addr_o
);
  initial begin
    rd_o = 1'b0;
    addr_o = 8'h00;
  end
  // Word fetch is two of these, low then high
  task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i) #1;
    rd_o = 1'b1;
    addr_o = a;
    @(posedge clk_sys_i) #1;
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask
endmodule

// [sim/ccr_readout_tb_top.sv]
// Testbench for the colour result readout
`timescale 1ns/1ns
module ccr_readout_tb_top;
  import ccr_pkg::*;
  logic       clk_sys_i = 0, sys_rst_i = 1, done = 0, irq = 0, sda_pl = 0, scl_pl = 0;
  logic [63:0] res = '0, live;
  logic [7:0] rdata, d, addr, sh, lo;
  logic       rd, int_oe_n, sda_oe_n, scl_oe_n, int_v, sda_v, scl_v, valid;
  int         fail_count = 0, n_tests = 0;
  initial forever #25 clk_sys_i = ~clk_sys_i;
  ccr_readout dut (.clk_sys_i, .sys_rst_i, .integ_done_i(done), .integ_result_i(res),
    .irq_assert_i(irq), .reg_rd_i(rd), .reg_addr_i(addr), .reg_rdata_o(rdata),
    .sda_pull_low_i(sda_pl), .scl_pull_low_i(scl_pl), .int_o(int_v), .int_oe_n_o(int_oe_n),
    .sda_o(sda_v), .sda_oe_n_o(sda_oe_n), .scl_o(scl_v), .scl_oe_n_o(scl_oe_n),
    .results_valid_flag_o(valid));
  ccr_host_model host (.clk_sys_i, .rdata_i(rdata), .rd_o(rd), .addr_o(addr));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] byte_of(input logic [63:0] r, input int ch, input int hi);
    return r[ch*16+hi*8 +: 8];
  endfunction
  task automatic load(input logic [63:0] r);
    @(posedge clk_sys_i) #1;
    res = r;
    done = 1'b1;
    @(posedge clk_sys_i) #1;
    done = 1'b0;
    res = ~r;
  endtask
  task automatic results;
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ==========
  // Stimulus
  initial begin
    void'($urandom(32'h2E2EED5E));
    repeat (16) @(posedge clk_sys_i);
    #1 sys_rst_i = 1'b0;
    host.rd_byte(CCR_STATUS_ADDR, d);
    chk(d, 8'h00);
    host.rd_byte(CCR_CLEAR_HI, d);
    chk(d, 8'h00);
    host.rd_byte(8'h00, d);
    chk(d, CCR_UNMAPPED);
    for (int i = 0; i < 12; i++) begin
      {sda_pl, scl_pl, irq} = 3'($urandom);
      #1 chk({5'h00, int_oe_n, sda_oe_n, scl_oe_n}, {5'h00, ~irq, ~sda_pl, ~scl_pl});
      chk({5'h00, int_v, sda_v, scl_v}, 8'h00);
      live = (i == 0) ? 64'hFFFF_0000_00FF_FF00 : {$urandom, $urandom};
      load(live);
      chk({7'h00, valid}, 8'h01);
      host.rd_byte(CCR_STATUS_ADDR, d);
      chk(d, 8'h01);
      for (int ch = 0; ch < 4; ch++) begin
        host.rd_byte(CCR_CLEAR_LO + 8'(2*ch), d);
        chk(d, byte_of(live, ch, 0));
        sh = byte_of(live, ch, 1);
        if (i[0]) begin
          live = {$urandom, $urandom};
          load(live);
        end
        host.rd_byte(CCR_CLEAR_HI + 8'(2*ch), d);
        chk(d, sh);
      end
      host.rd_byte(CCR_CLEAR_HI, d);
      chk(d, sh);
    end
    // Low read in the same cycle as an integration end
    lo = byte_of(live, 2, 0);
    sh = byte_of(live, 2, 1);
    live = {$urandom, $urandom};
    fork
      host.rd_byte(CCR_GREEN_LO, d);
      load(live);
    join
    chk(d, lo);
    host.rd_byte(CCR_GREEN_HI, d);
    chk(d, sh);
    host.rd_byte(CCR_GREEN_LO, d);
    chk(d, byte_of(live, 2, 0));
    // Reset again in mid-run
    @(posedge clk_sys_i) #1;
    sys_rst_i = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1 sys_rst_i = 1'b0;
    chk({7'h00, valid}, 8'h00);
    host.rd_byte(CCR_STATUS_ADDR, d);
    chk(d, 8'h00);
    host.rd_byte(CCR_BLUE_HI, d);
    chk(d, 8'h00);
    host.rd_byte(CCR_RED_LO, d);
    chk(d, 8'h00);
    results();
  end
endmodule
